// file: irq_ctrl_defines.vh
// register map, field positions, vectors and reset values of the interrupt controller
// Operation
// - arbitrate eleven interrupt sources plus master reset with minimal overhead
// - four dedicated external requests, two more when serial port one reconfigured
// - accept timer, byte DMA, both serial ports, software and power-down requests
// - fixed priority; all levels maskable except power-down and reset
// - programmable and serial-one alternate requests edge/level; level pins level, edge pin edge
// - fixed vector table 0000 to 0028, power-down at 002C
// - service nested with preemption or sequential, as configured
// - pending requests ANDed with mask; highest surviving priority selected
// - power-down request bypasses the mask
// - all interrupts masked for one cycle after a mask write
// - control register selects nesting and edge/level for three requests
// - edge request latched on active edge; software may force or clear it
// - force/clear register write-only, sets or clears pending requests
// - status pushed and popped on twelve-deep stacks at entry and return
// - global enable/disable gates all interrupts including power-down
// - global enable is set after reset
// - flag pins come out of reset as inputs; tri-stated when inactive
// - master reset empties stacks, masks all interrupts but power-down, clears mode status
// - power-down is nonmaskable edge request from pin or software force bit
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH
`define NUM_SRC 11
`define STACK_DEPTH 12
// byte addresses on the register bus
`define ADDR_MASK 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_FORCE 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_PEND 8'h10
`define ADDR_MODE_STATUS_REGISTER 8'h14
`define ADDR_FLAGDIR 8'h18
`define ADDR_FLAGOUT 8'h1c
`define ADDR_CMD 8'h20
// control register fields
`define CTRL_SENSE0 0
`define CTRL_SENSE1 1
`define CTRL_SENSE2 2
`define CTRL_NEST 4
`define CTRL_SP1_ALT 5
// command register bits
`define CMD_ENA 0
`define CMD_DIS 1
`define CMD_ACK 2
`define CMD_RTI 3
// force/clear: bits 10:0 force, bits 26:16 clear
`define FC_CLR_LSB 16
// source index, 0 = highest priority
`define SRC_PWD 0
`define SRC_PROG 1
`define SRC_LVL1 2
`define SRC_LVL0 3
`define SRC_SP0TX 4
`define SRC_SP0RX 5
`define SRC_EDGE 6
`define SRC_DMA 7
`define SRC_SP1TX 8
`define SRC_SP1RX 9
`define SRC_TIMER 10
`define VEC_RESET 14'h0000
`define VEC_PWD 14'h002c
`define MASK_RESET 11'h000
`define CTRL_RESET 8'h00
`endif

// file: dsp_interrupt_controller.v
// interrupt controller with AHB-Lite register slave, priority select and status stack
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"
module dsp_interrupt_controller #(
    parameter NSRC = `NUM_SRC,
    parameter DEPTH = `STACK_DEPTH
) (
    input wire clock,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire extReqProgrammableN,
    input wire extReqLevelOneN,
    input wire extReqLevelZeroN,
    input wire extReqEdgeN,
    input wire serial1AltReqZeroN,
    input wire serial1AltReqOneN,
    input wire powerDownN,
    input wire [3:0] progFlagIn,
    output wire [3:0] progFlagOut,
    output wire [3:0] progFlagOe,
    input wire serial0TxReq,
    input wire serial0RxReq,
    input wire serial1TxReq,
    input wire serial1RxReq,
    input wire dmaReq,
    input wire timerReq,
    input wire [15:0] statusIn,
    output wire irqValid,
    output wire [13:0] irqVector,
    output wire [15:0] statusOut,
    output wire stackEmpty,
    output wire stackFull
);
    // reset release through two flip-flops
    reg rstMeta_q;
    reg rstSync_q;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    wire rstN = rstSync_q;

    // pins are external: three stages, a change counts once stages two and three agree
    localparam NPIN = 7;
    wire [NPIN-1:0] pinRaw = ~{powerDownN, serial1AltReqOneN, serial1AltReqZeroN, extReqEdgeN,
                              extReqLevelZeroN, extReqLevelOneN, extReqProgrammableN};
    reg [NPIN-1:0] pin1_q;
    reg [NPIN-1:0] pin2_q;
    reg [NPIN-1:0] pin3_q;
    reg [NPIN-1:0] pinLvl_q;
    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            pin1_q <= 7'h00;
            pin2_q <= 7'h00;
            pin3_q <= 7'h00;
            pinLvl_q <= 7'h00;
        end else begin
            pin1_q <= pinRaw;
            pin2_q <= pin1_q;
            pin3_q <= pin2_q;
            pinLvl_q <= (pin2_q & pin3_q) | (pinLvl_q & (pin2_q | pin3_q));
        end
    end
    reg [NPIN-1:0] pinPrev_q;
    always @(posedge clock or negedge rstN) begin
        if (!rstN) pinPrev_q <= 7'h00;
        else pinPrev_q <= pinLvl_q;
    end
    wire [NPIN-1:0] pinRise = pinLvl_q & ~pinPrev_q;

    // software registers
    reg [NSRC-1:0] mask_q;
    reg [7:0] ctrl_q;
    reg [15:0] mode_status_register_q;
    reg [3:0] flagDir_q;
    reg [3:0] flagOut_q;
    reg globalEn_q;
    reg maskHold_q;
    reg [NSRC-1:0] latch_q;
    reg [NSRC-1:0] active_q;

    // ahb address phase capture
    reg wrPend_q;
    reg rdPend_q;
    reg [7:0] addr_q;
    wire take = hsel & hready & htrans[1];
    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wrPend_q <= take & hwrite;
            rdPend_q <= take & ~hwrite;
            if (take) addr_q <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire wrMask = wrPend_q && addr_q == `ADDR_MASK;
    wire wrCtrl = wrPend_q && addr_q == `ADDR_CTRL;
    wire wrForce = wrPend_q && addr_q == `ADDR_FORCE;
    wire wrMstat = wrPend_q && addr_q == `ADDR_MODE_STATUS_REGISTER;
    wire wrCmd = wrPend_q && addr_q == `ADDR_CMD;
    wire cmdAck = wrCmd & hwdata[`CMD_ACK];
    wire cmdRti = wrCmd & hwdata[`CMD_RTI];
    wire [NSRC-1:0] forceBits = wrForce ? hwdata[NSRC-1:0] : {NSRC{1'b0}};
    wire [NSRC-1:0] clearBits = wrForce ? hwdata[`FC_CLR_LSB+NSRC-1:`FC_CLR_LSB] : {NSRC{1'b0}};

    // raw level per source; alternate pins replace serial port one only when it is reconfigured
    wire alt = ctrl_q[`CTRL_SP1_ALT];
    wire [NSRC-1:0] rawLvl;
    assign rawLvl[`SRC_PWD] = 1'b0;
    assign rawLvl[`SRC_PROG] = pinLvl_q[0];
    assign rawLvl[`SRC_LVL1] = pinLvl_q[1];
    assign rawLvl[`SRC_LVL0] = pinLvl_q[2];
    assign rawLvl[`SRC_SP0TX] = serial0TxReq;
    assign rawLvl[`SRC_SP0RX] = serial0RxReq;
    assign rawLvl[`SRC_EDGE] = 1'b0; // the edge pin never acts as a level
    assign rawLvl[`SRC_DMA] = dmaReq;
    assign rawLvl[`SRC_SP1TX] = alt ? pinLvl_q[5] : serial1TxReq; // shares its slot with alternate one
    assign rawLvl[`SRC_SP1RX] = alt ? pinLvl_q[4] : serial1RxReq; // shares its slot with alternate zero
    assign rawLvl[`SRC_TIMER] = timerReq;
    // rising edges of the filtered pins, for the sources that can latch
    wire [NSRC-1:0] rawEdge;
    assign rawEdge[`SRC_PWD] = pinRise[6];
    assign rawEdge[`SRC_PROG] = pinRise[0];
    assign rawEdge[`SRC_LVL1] = 1'b0;
    assign rawEdge[`SRC_LVL0] = 1'b0;
    assign rawEdge[`SRC_SP0TX] = 1'b0;
    assign rawEdge[`SRC_SP0RX] = 1'b0;
    assign rawEdge[`SRC_EDGE] = pinRise[3];
    assign rawEdge[`SRC_DMA] = 1'b0;
    assign rawEdge[`SRC_SP1TX] = alt & pinRise[5];
    assign rawEdge[`SRC_SP1RX] = alt & pinRise[4];
    assign rawEdge[`SRC_TIMER] = 1'b0;
    // edge-sensitive sources: power-down and edge pin always, three more per control bits
    wire [NSRC-1:0] isEdge;
    assign isEdge[`SRC_PWD] = 1'b1;
    assign isEdge[`SRC_PROG] = ctrl_q[`CTRL_SENSE2];
    assign isEdge[`SRC_LVL1] = 1'b0;
    assign isEdge[`SRC_LVL0] = 1'b0;
    assign isEdge[`SRC_SP0TX] = 1'b0;
    assign isEdge[`SRC_SP0RX] = 1'b0;
    assign isEdge[`SRC_EDGE] = 1'b1;
    assign isEdge[`SRC_DMA] = 1'b0;
    assign isEdge[`SRC_SP1TX] = alt & ctrl_q[`CTRL_SENSE1];
    assign isEdge[`SRC_SP1RX] = alt & ctrl_q[`CTRL_SENSE0];
    assign isEdge[`SRC_TIMER] = 1'b0;
    // internal requests run on this clock and need no filter
    wire [NSRC-1:0] internalEvt;
    assign internalEvt[`SRC_PWD] = 1'b0;
    assign internalEvt[`SRC_PROG] = 1'b0;
    assign internalEvt[`SRC_LVL1] = 1'b0;
    assign internalEvt[`SRC_LVL0] = 1'b0;
    assign internalEvt[`SRC_SP0TX] = serial0TxReq;
    assign internalEvt[`SRC_SP0RX] = serial0RxReq;
    assign internalEvt[`SRC_EDGE] = 1'b0;
    assign internalEvt[`SRC_DMA] = dmaReq;
    assign internalEvt[`SRC_SP1TX] = serial1TxReq & ~alt;
    assign internalEvt[`SRC_SP1RX] = serial1RxReq & ~alt;
    assign internalEvt[`SRC_TIMER] = timerReq;
    // pending: edge sources latched, level sources follow the input or a forced latch
    wire [NSRC-1:0] pending = (isEdge & latch_q) | (~isEdge & (rawLvl | internalEvt) & ~latch_q)
                              | (~isEdge & latch_q);
    // mask gates all but power-down, which bypasses it
    wire [NSRC-1:0] effMask = {mask_q[NSRC-1:1], 1'b1};
    wire [NSRC-1:0] gated = pending & effMask & ~{NSRC{maskHold_q}};
    // nesting: only sources above the highest active may preempt
    reg [NSRC-1:0] allowed;
    reg [3:0] selIdx;
    reg selFound;
    reg seenActive;
    integer i;
    always @* begin
        allowed = {NSRC{1'b0}};
        seenActive = 1'b0;
        for (i = 0; i < NSRC; i = i + 1) begin
            if (active_q[i]) seenActive = 1'b1;
            allowed[i] = ~seenActive;
        end
        if (!ctrl_q[`CTRL_NEST] && (|active_q)) allowed = {NSRC{1'b0}};
        selFound = 1'b0;
        selIdx = 4'h0;
        for (i = NSRC - 1; i >= 0; i = i - 1) begin
            if (gated[i] && allowed[i]) begin
                selFound = 1'b1;
                selIdx = i[3:0];
            end
        end
    end
    reg [13:0] vecTab;
    always @* begin
        case (selIdx)
            4'd0: vecTab = `VEC_PWD;
            default: vecTab = {8'h00, selIdx, 2'b00};
        endcase
    end
    // global enable gates everything, power-down included
    wire fire = selFound & globalEn_q;
    reg irqValid_q;
    reg [13:0] irqVector_q;
    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            irqValid_q <= 1'b0;
            irqVector_q <= `VEC_RESET;
        end else begin
            irqValid_q <= fire & ~cmdAck;
            irqVector_q <= fire ? vecTab : irqVector_q;
        end
    end
    assign irqValid = irqValid_q;
    assign irqVector = irqVector_q;
    wire accept = cmdAck & irqValid_q;
    wire [NSRC-1:0] accBit = accept ? ({{(NSRC-1){1'b0}}, 1'b1} << irqVector_q[5:2]) : {NSRC{1'b0}};
    wire [NSRC-1:0] accSrc = (accept && irqVector_q == `VEC_PWD) ? {{(NSRC-1){1'b0}}, 1'b1} : accBit;

    // latched requests: a new edge wins over a clear
    always @(posedge clock or negedge rstN) begin
        if (!rstN) latch_q <= {NSRC{1'b0}};
        else latch_q <= (latch_q & ~clearBits & ~accSrc) | (rawEdge & isEdge) | forceBits;
    end

    // status stack, twelve deep, pushed on entry and popped on return
    reg [15:0] stack_q [0:DEPTH-1];
    reg [3:0] sp_q;
    reg [NSRC-1:0] actStack_q [0:DEPTH-1];
    assign stackEmpty = sp_q == 4'd0;
    assign stackFull = sp_q == DEPTH[3:0];
    wire push = accept & ~stackFull;
    wire pop = cmdRti & ~stackEmpty & ~push;
    integer k;
    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            sp_q <= 4'd0;
            active_q <= {NSRC{1'b0}};
            for (k = 0; k < DEPTH; k = k + 1) begin
                stack_q[k] <= 16'h0000;
                actStack_q[k] <= {NSRC{1'b0}};
            end
        end else if (push) begin
            stack_q[sp_q] <= mode_status_register_q;
            actStack_q[sp_q] <= active_q;
            active_q <= active_q | accSrc;
            sp_q <= sp_q + 4'd1;
        end else if (pop) begin
            active_q <= actStack_q[sp_q - 4'd1];
            sp_q <= sp_q - 4'd1;
        end
    end
    assign statusOut = stackEmpty ? 16'h0000 : stack_q[sp_q - 4'd1];

    // control registers
    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            mask_q <= `MASK_RESET;
            ctrl_q <= `CTRL_RESET;
            mode_status_register_q <= 16'h0000;
            flagDir_q <= 4'h0;
            flagOut_q <= 4'h0;
            globalEn_q <= 1'b1;
            maskHold_q <= 1'b0;
        end else begin
            maskHold_q <= wrMask;
            if (wrMask) mask_q <= hwdata[NSRC-1:0];
            if (wrCtrl) ctrl_q <= hwdata[7:0];
            if (wrMstat) mode_status_register_q <= hwdata[15:0];
            else if (pop) mode_status_register_q <= stack_q[sp_q - 4'd1];
            else if (push) mode_status_register_q <= statusIn;
            if (wrPend_q && addr_q == `ADDR_FLAGDIR) flagDir_q <= hwdata[3:0];
            if (wrPend_q && addr_q == `ADDR_FLAGOUT) flagOut_q <= hwdata[3:0];
            if (wrCmd && hwdata[`CMD_DIS]) globalEn_q <= 1'b0;
            else if (wrCmd && hwdata[`CMD_ENA]) globalEn_q <= 1'b1;
        end
    end
    // flag pins drive only when set as output; otherwise released
    assign progFlagOut = flagOut_q;
    assign progFlagOe = flagDir_q;

    // read data, registered at the end of the address phase; force/clear reads zero
    always @(posedge clock or negedge rstN) begin
        if (!rstN) hrdata <= 32'h00000000;
        else if (take && !hwrite) begin
            case (haddr[7:0])
                `ADDR_MASK: hrdata <= {21'h000000, mask_q};
                `ADDR_CTRL: hrdata <= {24'h000000, ctrl_q};
                `ADDR_STATUS: hrdata <= {16'h0000, globalEn_q, irqValid_q, sp_q, irqVector_q[5:0], 4'h0};
                `ADDR_PEND: hrdata <= {5'h00, active_q, 5'h00, pending};
                `ADDR_MODE_STATUS_REGISTER: hrdata <= {16'h0000, mode_status_register_q};
                `ADDR_FLAGDIR: hrdata <= {28'h0000000, flagDir_q};
                `ADDR_FLAGOUT: hrdata <= {24'h000000, progFlagIn, flagOut_q};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// file: irq_ctrl_checker.sv
// port assertions for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_checker #(parameter NSRC = 11, parameter DEPTH = 12) (
    input wire clock,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [3:0] progFlagOe,
    input wire irqValid,
    input wire [13:0] irqVector,
    input wire [15:0] statusOut,
    input wire stackEmpty,
    input wire stackFull
);
    reg maskWr_q;
    reg cmdWr_q;
    reg forceRd_q;
    reg rstSeen_q = 1'b0;
    wire take = hsel && hready && htrans[1];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // note the address phase so its data phase can be judged
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            maskWr_q <= 1'b0;
            cmdWr_q <= 1'b0;
            forceRd_q <= 1'b0;
        end else begin
            maskWr_q <= take && hwrite && haddr[7:0] == 8'h00;
            cmdWr_q <= take && hwrite && haddr[7:0] == 8'h20;
            forceRd_q <= take && !hwrite && haddr[7:0] == 8'h08;
        end
    end
    // the first edge in reset only starts it, so reset outputs are judged from the second on
    always @(posedge clock) rstSeen_q <= !nrst;
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered error");
    chk_vec_legal: assert property (irqValid |-> irqVector[1:0] == 2'b00
        && irqVector >= 14'h0004 && irqVector <= 14'h002c) else $error("vector outside table");
    chk_reset_state: assert property (disable iff (1'b0) rstSeen_q && !nrst |->
        progFlagOe == 4'h0 && !irqValid && stackEmpty) else $error("reset state wrong");
    chk_stack_excl: assert property (!(stackEmpty && stackFull))
        else $error("stack empty and full together");
    chk_empty_zero: assert property (stackEmpty |-> statusOut == 16'h0000)
        else $error("empty stack shows status");
    chk_mask_hold: assert property (maskWr_q |=> ##1 !irqValid)
        else $error("request raised right after mask write");
    chk_ack_push: assert property (cmdWr_q && hwdata[2] && irqValid && stackEmpty
        |-> ##[1:2] !stackEmpty) else $error("ack did not push status");
    chk_force_read: assert property (forceRd_q |-> hrdata == 32'h0)
        else $error("force register read back data");
endmodule
bind dsp_interrupt_controller irq_ctrl_checker #(.NSRC(NSRC), .DEPTH(DEPTH)) chk (.clock(clock), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .progFlagOe(progFlagOe), .irqValid(irqValid),
    .irqVector(irqVector), .statusOut(statusOut), .stackEmpty(stackEmpty), .stackFull(stackFull));

// file: ext_src_model.sv
// external request pins, flag pin wiring and sequencer status source
`timescale 1ns/1ps
module ext_src_model (
    input wire clock,
    input wire [6:0] reqLevel,
    input wire [3:0] flagOut,
    input wire [3:0] flagOe,
    output wire [6:0] pinN,
    output wire [3:0] flagPin,
    output reg [15:0] status_q
);
    initial status_q = 16'h0001;
    // status changes every cycle so a stale copy never looks right
    always @(posedge clock) status_q <= status_q + 16'h0001;
    // idle sources rest at the pull-up level
    assign pinN = ~reqLevel;
    // an undriven flag pin floats up to its pull-up
    assign flagPin = (flagOut & flagOe) | ~flagOe;
endmodule

// file: tb.sv
// self-checking bench: bus tasks and interrupt scenarios
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [10:0] reqs = 11'h000;
    logic [1:0] altReqs = 2'b00;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irqValid, stackEmpty, stackFull;
    wire [13:0] irqVector;
    wire [15:0] statusIn, statusOut;
    wire [6:0] pinN;
    wire [3:0] flagIn, flagOut, flagOe;
    int miscompares = 0;
    int n_compared = 0;
    always #5 clock = ~clock;
    ext_src_model model (.clock(clock), .reqLevel({reqs[0], altReqs, reqs[6], reqs[3], reqs[2], reqs[1]}),
        .flagOut(flagOut), .flagOe(flagOe), .pinN(pinN), .flagPin(flagIn), .status_q(statusIn));
    dsp_interrupt_controller uut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .extReqProgrammableN(pinN[0]), .extReqLevelOneN(pinN[1]),
        .extReqLevelZeroN(pinN[2]), .extReqEdgeN(pinN[3]), .serial1AltReqZeroN(pinN[4]),
        .serial1AltReqOneN(pinN[5]), .powerDownN(pinN[6]), .progFlagIn(flagIn), .progFlagOut(flagOut),
        .progFlagOe(flagOe), .serial0TxReq(reqs[4]), .serial0RxReq(reqs[5]), .serial1TxReq(reqs[8]),
        .serial1RxReq(reqs[9]), .dmaReq(reqs[7]), .timerReq(reqs[10]), .statusIn(statusIn),
        .irqValid(irqValid), .irqVector(irqVector), .statusOut(statusOut), .stackEmpty(stackEmpty),
        .stackFull(stackFull));
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // bounded wait for the slave to accept the current phase
    task waitReady;
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                test_done;
            end
            @(posedge clock);
        end
    endtask
    // one single-word transfer; read data is taken at the data phase's closing edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        waitReady;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitReady;
        rd = hrdata;
    endtask
    task waitIrq(input logic [13:0] vec);
        int n;
        n = 0;
        while (irqValid !== 1'b1) begin
            n++;
            if (n > 40) begin
                miscompares++;
                test_done;
            end
            @(posedge clock);
        end
        check({18'h0, irqVector}, {18'h0, vec});
    endtask
    task quiet;
        repeat (12) @(posedge clock);
        check({31'h0, irqValid}, 32'h0);
    endtask
    // ack, drop the sources, then return from every nested level
    task serve(input int pops);
        bus(1'b1, 8'h20, 32'h4);
        reqs <= 11'h000;
        altReqs <= 2'b00;
        repeat (8) @(posedge clock);
        check({31'h0, stackEmpty | irqValid}, 32'h0);
        repeat (pops) bus(1'b1, 8'h20, 32'h8);
        repeat (2) @(posedge clock);
        check({31'h0, stackEmpty}, 32'h1);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h3c, 32'h0);
        check(rd, 32'h0);
        // flag 0 and 2 driven, 1 and 3 released to their pull-ups
        bus(1'b1, 8'h18, 32'h5);
        bus(1'b1, 8'h1c, 32'h1);
        bus(1'b0, 8'h1c, 32'h0);
        check(rd, 32'hb1);
        // every source alone; edge sources pulse and must stay latched
        for (int i = 0; i < 11; i++) begin
            bus(1'b1, 8'h00, 32'h1 << i);
            reqs <= 11'h1 << i;
            if (i == 0 || i == 6) begin
                repeat (6) @(posedge clock);
                reqs <= 11'h000;
            end
            waitIrq(i == 0 ? 14'h002c : 14'(i * 4));
            serve(1);
        end
        // serial port one reconfigured: alternate zero as level, then alternate one as edge
        bus(1'b1, 8'h04, 32'h20);
        bus(1'b1, 8'h00, 32'h300);
        altReqs <= 2'b01;
        waitIrq(14'h0024);
        serve(1);
        bus(1'b1, 8'h04, 32'h22);
        altReqs <= 2'b10;
        repeat (6) @(posedge clock);
        altReqs <= 2'b00;
        waitIrq(14'h0020);
        serve(1);
        bus(1'b1, 8'h00, 32'h400);
        reqs <= 11'h410;
        waitIrq(14'h0028);
        bus(1'b1, 8'h20, 32'h4);
        bus(1'b1, 8'h00, 32'h7fe);
        quiet;
        bus(1'b1, 8'h04, 32'h10);
        waitIrq(14'h0010);
        serve(2);
        bus(1'b1, 8'h20, 32'h2);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h08, 32'h1);
        quiet;
        bus(1'b1, 8'h20, 32'h1);
        waitIrq(14'h002c);
        serve(1);
        bus(1'b1, 8'h20, 32'h2);
        bus(1'b1, 8'h00, 32'h40);
        bus(1'b1, 8'h08, 32'h40);
        bus(1'b1, 8'h08, 32'h400000);
        bus(1'b1, 8'h20, 32'h1);
        quiet;
        bus(1'b1, 8'h08, 32'h40);
        waitIrq(14'h0018);
        // the word pushed on entry is the mode status in force, and return restores it
        bus(1'b1, 8'h14, 32'h1234);
        bus(1'b1, 8'h20, 32'h4);
        @(posedge clock);
        check({16'h0, statusOut}, 32'h1234);
        serve(1);
        bus(1'b0, 8'h14, 32'h0);
        check(rd, 32'h1234);
        // mid-run reset with a status on the stack and interrupts disabled
        bus(1'b1, 8'h00, 32'h400);
        bus(1'b1, 8'h08, 32'h400);
        waitIrq(14'h0028);
        bus(1'b1, 8'h20, 32'h6);
        @(posedge clock);
        check({31'h0, stackEmpty}, 32'h0);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        check({31'h0, stackEmpty}, 32'h1);
        bus(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h8000);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        test_done;
    end
endmodule
